// ===== hdl/nfc_ctrl.sv
// Host controller that drives a parallel NOR flash from AHB-Lite registers.
//
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`include "nfc_map.svh"

module nfc_ctrl
   import nfc_pkg::*;
#(
   parameter int BUSY_CYC = `NFC_CYC(`NFC_T_BUSY_NS),
   parameter int RST_CYC = `NFC_CYC(`NFC_T_RST_NS),
   parameter int RREC_CYC = `NFC_CYC(`NFC_T_RREC_NS)
)
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // AHB-Lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic [31:0] o_hrdata,
   output logic o_hresp,
   // Flash pins
   input wire logic [15:0] i_dq_in,
   input wire logic i_done_flag_pin,
   output nfc_pins_t o_flash,
   output logic o_flash_rst_n
);

   if (BUSY_CYC < 1 || BUSY_CYC > 255 || RST_CYC < 1 || RST_CYC > 255 ||
       RREC_CYC < 1 || RREC_CYC > 255)
      $error("nfc_ctrl: wait counts must lie in 1..255");

   nfc_ctl_st_t s;
   nfc_ctl_st_t next_s;
   logic cyc_done;
   logic [15:0] cyc_rdata;
   logic abort;

   // =============================================================
   // Command sequence tables
   function automatic logic [2:0] seq_len(nfc_op_t op, logic byp);
      case (op)
         OP_PROG: seq_len = byp ? 3'd2 : 3'd4;
         OP_CHIP_ER, OP_SECT_ER: seq_len = 3'd6;
         OP_BYP_ON: seq_len = 3'd3;
         OP_BYP_OFF: seq_len = 3'd2;
         default: seq_len = 3'd1;
      endcase
   endfunction : seq_len

   function automatic nfc_word_t step_word(nfc_op_t op, logic [2:0] i,
      logic byp, logic x16, logic [18:0] a, logic [15:0] d);
      logic [18:0] u1;
      logic [18:0] u2;
      u1 = x16 ? `NFC_UNL1_X16 : `NFC_UNL1_X8;
      u2 = x16 ? `NFC_UNL2_X16 : `NFC_UNL2_X8;
      step_word = '{addr: u1, data: `NFC_CMD_AA};
      if (i == 3'd1 || i == 3'd4)
         step_word = '{addr: u2, data: `NFC_CMD_55};
      case (op)
         OP_PROG:
            if (byp)
               step_word = '{addr: a,
                             data: (i == 3'd0) ? `NFC_CMD_PROG : d};
            else if (i == 3'd2)
               step_word.data = `NFC_CMD_PROG;
            else if (i == 3'd3)
               step_word = '{addr: a, data: d};
         OP_CHIP_ER, OP_SECT_ER:
            if (i == 3'd2)
               step_word.data = `NFC_CMD_ERASE;
            else if (i == 3'd5 && op == OP_CHIP_ER)
               step_word.data = `NFC_CMD_CHIP;
            else if (i == 3'd5)
               step_word = '{addr: a, data: `NFC_CMD_SECT};
         OP_BYP_ON:
            if (i == 3'd2)
               step_word.data = `NFC_CMD_BYP;
         OP_BYP_OFF:
            step_word = '{addr: a, data: (i == 3'd0) ? `NFC_CMD_BYPX1
                                                      : `NFC_CMD_BYPX2};
         OP_SUSPEND: step_word = '{addr: a, data: `NFC_CMD_SUSP};
         OP_RESUME: step_word = '{addr: a, data: `NFC_CMD_RESUME};
         OP_SOFT_RST: step_word = '{addr: a, data: `NFC_CMD_SRST};
         default: step_word = '{addr: a, data: d};
      endcase
   endfunction : step_word

   // An order is taken only where the device can accept it.
   function automatic logic op_ok(nfc_ctl_st_t c, logic [3:0] code);
      case (code)
         OP_HW_RST: op_ok = 1'b1;
         OP_SUSPEND: op_ok = c.erasing && !c.suspended &&
            (c.st == S_POLL || c.st == S_IDLE);
         OP_READ, OP_PROG, OP_SOFT_RST: op_ok = c.st == S_IDLE;
         OP_CHIP_ER, OP_SECT_ER, OP_BYP_ON:
            op_ok = c.st == S_IDLE && !c.bypass && !c.suspended;
         OP_BYP_OFF: op_ok = c.st == S_IDLE && c.bypass;
         OP_RESUME: op_ok = c.st == S_IDLE && c.suspended;
         default: op_ok = 1'b0;
      endcase
   endfunction : op_ok

   // =============================================================
   // Bus slave and sequencer
   always_comb
   begin
      next_s = s;
      next_s.cyc_start = 1'b0;
      next_s.wpend = 1'b0;
      next_s.hreadyout = 1'b1;
      if (i_hsel && i_hready && i_htrans[1])
      begin
         next_s.wpend = i_hwrite;
         next_s.waddr = i_haddr[7:0];
         case (i_haddr[7:0])
            `NFC_REG_CTRL: next_s.hrdata = {28'h0000000, s.op};
            `NFC_REG_ADDR: next_s.hrdata = {13'h0000, s.addr};
            `NFC_REG_WDATA: next_s.hrdata = {16'h0000, s.wdata};
            `NFC_REG_CFG: next_s.hrdata = {31'h00000000, s.x16};
            `NFC_REG_STATUS: next_s.hrdata = {26'h0000000, i_done_flag_pin,
               s.erasing, s.refused, s.bypass, s.suspended,
               s.st != S_IDLE};
            `NFC_REG_RDATA: next_s.hrdata = {16'h0000, s.rdata};
            default: next_s.hrdata = 32'h00000000;
         endcase
      end
      case (s.st)
         S_ISSUE:
         begin
            next_s.cyc_start = 1'b1;
            next_s.cyc_wr = s.run_op != OP_READ;
            next_s.st = S_CYC;
         end
         S_CYC:
            if (cyc_done)
            begin
               if (s.run_op == OP_READ)
                  next_s.rdata = cyc_rdata;
               if (s.idx != s.len - 3'd1)
               begin
                  next_s.idx = s.idx + 3'd1;
                  next_s.st = S_ISSUE;
               end
               else
               begin
                  next_s.st = S_IDLE;
                  case (s.run_op)
                     OP_PROG, OP_CHIP_ER, OP_SECT_ER, OP_SUSPEND, OP_RESUME:
                     begin
                        next_s.st = S_SETTLE;
                        next_s.cnt = 8'(BUSY_CYC - 1);
                     end
                     OP_BYP_ON: next_s.bypass = 1'b1;
                     OP_BYP_OFF: next_s.bypass = 1'b0;
                     default: next_s.bypass = s.bypass;
                  endcase
                  if (s.run_op == OP_CHIP_ER || s.run_op == OP_SECT_ER)
                     next_s.erasing = 1'b1;
                  if (s.run_op == OP_SUSPEND)
                     next_s.suspended = 1'b1;
                  if (s.run_op == OP_RESUME)
                     next_s.suspended = 1'b0;
               end
            end
         S_SETTLE:
            if (s.cnt == 8'h00)
               next_s.st = S_POLL;
            else
               next_s.cnt = s.cnt - 8'h01;
         S_POLL:
            if (i_done_flag_pin)
            begin
               next_s.st = S_IDLE;
               // A finished suspend leaves the erase pending.
               if (s.run_op != OP_SUSPEND && !s.suspended)
                  next_s.erasing = 1'b0;
            end
         S_RLOW:
            if (s.cnt == 8'h00)
            begin
               next_s.rst_n = 1'b1;
               next_s.st = S_RREC;
               next_s.cnt = 8'(RREC_CYC - 1);
            end
            else
               next_s.cnt = s.cnt - 8'h01;
         S_RREC:
            if (s.cnt == 8'h00)
               next_s.st = S_IDLE;
            else
               next_s.cnt = s.cnt - 8'h01;
         default:
            next_s.st = S_IDLE;
      endcase
      if (s.wpend)
      begin
         case (s.waddr)
            `NFC_REG_ADDR: next_s.addr = i_hwdata[18:0];
            `NFC_REG_WDATA: next_s.wdata = i_hwdata[15:0];
            `NFC_REG_CFG: next_s.x16 = i_hwdata[`NFC_CFG_X16];
            `NFC_REG_STATUS:
               if (i_hwdata[`NFC_ST_REFUSED])
                  next_s.refused = 1'b0;
            default: next_s.x16 = next_s.x16;
         endcase
      end
      // The order is applied after the clear so a refusal is not lost.
      if (s.wpend && s.waddr == `NFC_REG_CTRL)
      begin
         next_s.op = nfc_op_t'(i_hwdata[3:0]);
         if (!op_ok(s, i_hwdata[3:0]))
            next_s.refused = 1'b1;
         else if (i_hwdata[3:0] == OP_HW_RST)
         begin
            next_s.st = S_RLOW;
            next_s.cnt = 8'(RST_CYC - 1);
            next_s.rst_n = 1'b0;
            next_s.bypass = 1'b0;
            next_s.suspended = 1'b0;
            next_s.erasing = 1'b0;
         end
         else
         begin
            next_s.run_op = nfc_op_t'(i_hwdata[3:0]);
            next_s.idx = 3'd0;
            next_s.len = seq_len(nfc_op_t'(i_hwdata[3:0]), s.bypass);
            next_s.st = S_ISSUE;
         end
      end
   end

   assign abort = s.st == S_RLOW;

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         s <= '0;
         s.st <= S_IDLE;
         s.op <= OP_READ;
         s.run_op <= OP_READ;
         s.x16 <= `NFC_CFG_RESET;
         s.rst_n <= 1'b1;
         s.hreadyout <= 1'b1;
      end
      else
         s <= next_s;
   end

   nfc_cycle u_cycle (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_start(s.cyc_start),
      .i_abort(abort),
      .i_wr(s.cyc_wr),
      .i_x16(s.x16),
      .i_word(step_word(s.run_op, s.idx, s.bypass, s.x16, s.addr,
                        s.wdata)),
      .o_done(cyc_done),
      .o_rdata(cyc_rdata),
      .i_dq_in(i_dq_in),
      .o_pins(o_flash)
   );

   assign o_hreadyout = s.hreadyout;
   assign o_hrdata = s.hrdata;
   assign o_hresp = 1'b0;
   assign o_flash_rst_n = s.rst_n;

   // =============================================================
   // Checks
   a_prog_write_count: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (s.st == S_ISSUE && s.idx == 3'd0 && s.run_op == OP_PROG) |->
         s.len == (s.bypass ? 3'd2 : 3'd4))
      else $error("program sequence length wrong for mode");
   a_resume_when_held: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (s.st == S_ISSUE && s.run_op == OP_RESUME) |-> s.suspended)
      else $error("resume issued with no erase on hold");
   a_idle_standby: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (s.st == S_IDLE && $past(s.st) == S_IDLE) |-> o_flash.ce_n)
      else $error("chip selected while controller idle");
   a_busy_no_command: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (s.st == S_ISSUE && $past(s.st) == S_POLL) |->
         s.run_op == OP_SUSPEND && s.erasing)
      else $error("command other than suspend while busy");
   a_command_is_write: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (s.cyc_start && s.run_op != OP_READ) |-> ##[2:4] !o_flash.ce_n
         && o_flash.dq_oe)
      else $error("command not issued as a write cycle");

endmodule : nfc_ctrl

// ===== hdl/nfc_map.svh
// Register map, command codes and timing counts of the flash controller.
`ifndef NFC_MAP_SVH
`define NFC_MAP_SVH

// =============================================================
// Register offsets (byte addresses on the AHB-Lite bus)
`define NFC_REG_CTRL 8'h00
`define NFC_REG_ADDR 8'h04
`define NFC_REG_WDATA 8'h08
`define NFC_REG_CFG 8'h0c
`define NFC_REG_STATUS 8'h10
`define NFC_REG_RDATA 8'h14

// =============================================================
// Field positions
`define NFC_CFG_X16 0
`define NFC_ST_BUSY 0
`define NFC_ST_SUSP 1
`define NFC_ST_BYP 2
`define NFC_ST_REFUSED 3
`define NFC_ST_ERASING 4
`define NFC_ST_DONE_PIN 5
`define NFC_CFG_RESET 1'b1

// =============================================================
// Unlock addresses for word and byte mode, and command data
`define NFC_UNL1_X16 19'h00555
`define NFC_UNL2_X16 19'h002aa
`define NFC_UNL1_X8 19'h00aaa
`define NFC_UNL2_X8 19'h00555
`define NFC_CMD_AA 16'h00aa
`define NFC_CMD_55 16'h0055
`define NFC_CMD_PROG 16'h00a0
`define NFC_CMD_ERASE 16'h0080
`define NFC_CMD_CHIP 16'h0010
`define NFC_CMD_SECT 16'h0030
`define NFC_CMD_BYP 16'h0020
`define NFC_CMD_BYPX1 16'h0090
`define NFC_CMD_BYPX2 16'h0000
`define NFC_CMD_SUSP 16'h00b0
`define NFC_CMD_RESUME 16'h0030
`define NFC_CMD_SRST 16'h00f0

// =============================================================
// Times in ns and their cycle counts (least times, rounded up)
`define NFC_CLK_NS 4
`define NFC_T_SETUP_NS 10
`define NFC_T_PULSE_NS 120
`define NFC_T_HOLD_NS 20
`define NFC_T_BUSY_NS 100
`define NFC_T_RST_NS 500
`define NFC_T_RREC_NS 50
`define NFC_CYC(ns) (((ns) + `NFC_CLK_NS - 1) / `NFC_CLK_NS)

`endif

// ===== hdl/nfc_pkg.sv
// Types shared by the flash controller modules.
package nfc_pkg;

   typedef enum logic [3:0] {
      OP_READ = 4'h0, OP_PROG = 4'h1, OP_CHIP_ER = 4'h2, OP_SECT_ER = 4'h3,
      OP_SUSPEND = 4'h4, OP_RESUME = 4'h5, OP_BYP_ON = 4'h6,
      OP_BYP_OFF = 4'h7, OP_SOFT_RST = 4'h8, OP_HW_RST = 4'h9
   } nfc_op_t;

   typedef struct packed {
      logic ce_n;
      logic we_n;
      logic oe_n;
      logic byte_n;
      logic [18:0] addr;
      logic [15:0] dq_out;
      logic dq_oe;
   } nfc_pins_t;

   typedef struct packed {
      logic [18:0] addr;
      logic [15:0] data;
   } nfc_word_t;

   typedef enum logic [3:0] {
      C_IDLE = 4'b0001, C_SETUP = 4'b0010, C_STROBE = 4'b0100,
      C_HOLD = 4'b1000
   } nfc_cph_t;

   typedef struct packed {
      nfc_cph_t ph;
      logic [7:0] cnt;
      logic wr;
      logic x16;
      logic done;
      logic [15:0] rdata;
      nfc_pins_t pins;
   } nfc_cyc_st_t;

   typedef enum logic [6:0] {
      S_IDLE = 7'b0000001, S_ISSUE = 7'b0000010, S_CYC = 7'b0000100,
      S_SETTLE = 7'b0001000, S_POLL = 7'b0010000, S_RLOW = 7'b0100000,
      S_RREC = 7'b1000000
   } nfc_state_t;

   typedef struct packed {
      nfc_state_t st;
      nfc_op_t op;
      nfc_op_t run_op;
      logic [2:0] idx;
      logic [2:0] len;
      logic [7:0] cnt;
      logic [18:0] addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic x16;
      logic bypass;
      logic suspended;
      logic erasing;
      logic refused;
      logic rst_n;
      logic cyc_start;
      logic cyc_wr;
      logic wpend;
      logic [7:0] waddr;
      logic hreadyout;
      logic [31:0] hrdata;
   } nfc_ctl_st_t;

endpackage : nfc_pkg

// ===== hdl/nfc_cycle.sv
// One asynchronous read or write cycle on the flash pins.
`timescale 1ns/1ns
`include "nfc_map.svh"

module nfc_cycle
   import nfc_pkg::*;
#(
   parameter int SETUP_CYC = `NFC_CYC(`NFC_T_SETUP_NS),
   parameter int PULSE_CYC = `NFC_CYC(`NFC_T_PULSE_NS),
   parameter int HOLD_CYC = `NFC_CYC(`NFC_T_HOLD_NS)
)
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Request
   input wire logic i_start,
   input wire logic i_abort,
   input wire logic i_wr,
   input wire logic i_x16,
   input nfc_word_t i_word,
   output logic o_done,
   output logic [15:0] o_rdata,
   // Flash pins
   input wire logic [15:0] i_dq_in,
   output nfc_pins_t o_pins
);

   if (SETUP_CYC < 1 || SETUP_CYC > 255 || PULSE_CYC < 1 ||
       PULSE_CYC > 255 || HOLD_CYC < 1 || HOLD_CYC > 255)
      $error("nfc_cycle: phase counts must lie in 1..255");

   nfc_cyc_st_t s;
   nfc_cyc_st_t next_s;

   // =============================================================
   // Phase sequencing
   always_comb
   begin
      next_s = s;
      next_s.done = 1'b0;
      case (s.ph)
         C_IDLE:
            if (i_start)
            begin
               next_s.ph = C_SETUP;
               next_s.cnt = 8'(SETUP_CYC - 1);
               next_s.wr = i_wr;
               next_s.x16 = i_x16;
               next_s.pins.ce_n = 1'b0;
               next_s.pins.byte_n = i_x16;
               next_s.pins.addr = i_word.addr;
               next_s.pins.dq_out = i_x16 ? i_word.data
                                          : {8'h00, i_word.data[7:0]};
               next_s.pins.dq_oe = i_wr;
            end
         C_SETUP:
            if (s.cnt == 8'h00)
            begin
               next_s.ph = C_STROBE;
               next_s.cnt = 8'(PULSE_CYC - 1);
               next_s.pins.we_n = !s.wr;
               next_s.pins.oe_n = s.wr;
            end
            else
               next_s.cnt = s.cnt - 8'h01;
         C_STROBE:
            if (s.cnt == 8'h00)
            begin
               // The pulse time covers the access time, so data is
               // taken in the last strobe cycle before output turns off.
               if (!s.wr)
                  next_s.rdata = s.x16 ? i_dq_in : {8'h00, i_dq_in[7:0]};
               next_s.ph = C_HOLD;
               next_s.cnt = 8'(HOLD_CYC - 1);
               next_s.pins.we_n = 1'b1;
               next_s.pins.oe_n = 1'b1;
            end
            else
               next_s.cnt = s.cnt - 8'h01;
         C_HOLD:
            if (s.cnt == 8'h00)
            begin
               next_s.ph = C_IDLE;
               next_s.pins.ce_n = 1'b1;
               next_s.pins.dq_oe = 1'b0;
               next_s.done = 1'b1;
            end
            else
               next_s.cnt = s.cnt - 8'h01;
         default:
            next_s.ph = C_IDLE;
      endcase
      if (i_abort)
      begin
         next_s.ph = C_IDLE;
         next_s.done = 1'b0;
         next_s.pins.ce_n = 1'b1;
         next_s.pins.we_n = 1'b1;
         next_s.pins.oe_n = 1'b1;
         next_s.pins.dq_oe = 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         s <= '0;
         s.ph <= C_IDLE;
         s.pins.ce_n <= 1'b1;
         s.pins.we_n <= 1'b1;
         s.pins.oe_n <= 1'b1;
         s.pins.byte_n <= 1'b1;
      end
      else
         s <= next_s;
   end

   assign o_done = s.done;
   assign o_rdata = s.rdata;
   assign o_pins = s.pins;

   // =============================================================
   // Checks
   a_strobes_exclusive: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      !(!s.pins.we_n && !s.pins.oe_n))
      else $error("write and output strobes low together");
   a_drive_only_oe_high: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      s.pins.dq_oe |-> s.pins.oe_n && !s.pins.ce_n)
      else $error("data bus driven while outputs selected");
   a_write_in_select: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      $fell(s.pins.we_n) |-> !s.pins.ce_n && s.pins.dq_oe
         ##1 !s.pins.ce_n)
      else $error("write strobe outside a chip-selected write");

endmodule : nfc_cycle

// ===== verification/nfc_flash_model.sv
// Behavioural model of the parallel NOR flash seen by the controller.
`timescale 1ns/1ns

module nfc_flash_model
   import nfc_pkg::*;
#(
   parameter int PROG_NS = 400,
   parameter int ERASE_NS = 4000,
   parameter int PROT = 9,
   parameter bit TOP_BOOT = 0
)
(
   // Flash pins
   input nfc_pins_t i_pins,
   input wire logic i_rst_n,
   // Answers
   output logic [15:0] o_dq,
   output logic o_done_flag_pin
);
   logic [15:0] mem [int];
   logic [18:0] a1 = 0, a2 = 0;
   logic [7:0] d1 = 0, d2 = 0;
   logic [15:0] last = 0;
   int left = 0;
   bit susp, byp, arm, pprog, pexit, ers, tog;

   function automatic logic [15:0] rd(input logic [18:0] a);
      return mem.exists(a) ? mem[a] : 16'hffff;
   endfunction : rd

   // Four boot sectors fill the lowest 64K, then seven of 64K follow.
   // A top-boot part mirrors the map, so its numbering runs downwards.
   function automatic int sec(input logic [18:0] a);
      logic [18:0] b;
      b = TOP_BOOT ? ~a : a;
      if (b[18:16] != 3'h0) return 3 + int'(b[18:16]);
      else if (b[15]) return 3;
      else if (b[14]) return b[13] ? 2 : 1;
      return 0;
   endfunction : sec

   function automatic bit unl();
      logic x;
      x = i_pins.byte_n;
      return d2 == 8'haa && d1 == 8'h55 && a2 == (x ? 19'h555 : 19'haaa)
         && a1 == (x ? 19'h2aa : 19'h555);
   endfunction : unl

   task automatic ers_go(input logic [18:0] a, input bit all);
      foreach (mem[k])
         if ((all || sec(19'(k)) == sec(a)) &&
             sec(19'(k)) != PROT)
            mem[k] = 16'hffff;
      arm = 0;
      ers = 1;
      left = ERASE_NS;
   endtask : ers_go

   // Address and data are latched on the rising write strobe.
   always @(posedge i_pins.we_n)
   begin
      logic [18:0] a;
      logic [15:0] d;
      a = i_pins.addr;
      d = i_pins.byte_n ? i_pins.dq_out : {8'hff, i_pins.dq_out[7:0]};
      if (!i_pins.ce_n && i_pins.dq_oe && i_rst_n)
      begin
         if (pprog)
         begin
            pprog = 0;
            ers = 0;
            if (sec(a) != PROT) mem[a] = rd(a) & d;
            left = PROG_NS;
         end
         else if (d[7:0] == 8'hf0) arm = 0;
         else if (byp && d[7:0] == 8'h90) pexit = 1;
         else if (pexit && d[7:0] == 8'h00) {byp, pexit} = 2'b00;
         else if (byp && d[7:0] == 8'ha0) pprog = 1;
         else if (ers && left > 0 && d[7:0] == 8'hb0) susp = 1;
         else if (susp && d[7:0] == 8'h30 && !unl()) susp = 0;
         else if (unl() && d[7:0] == 8'ha0) pprog = 1;
         else if (unl() && d[7:0] == 8'h20) byp = 1;
         else if (unl() && d[7:0] == 8'h80) arm = 1;
         else if (unl() && arm && d[7:0] == 8'h10) ers_go(a, 1);
         else if (unl() && arm && d[7:0] == 8'h30) ers_go(a, 0);
         {a2, a1, d2, d1} = {a1, a, d1, d[7:0]};
      end
   end

   always #4
      if (left > 0 && !susp) left = left - 4;
   always @(negedge i_rst_n)
      {left, susp, byp, arm, pprog, pexit, ers} = '0;
   assign o_done_flag_pin = left == 0 || susp;
   always @(negedge i_pins.oe_n) tog = ~tog;
   always @(posedge i_pins.oe_n) last = o_dq;
   // A released bus shows the inverse of the last value, not a held copy.
   always @*
      if (!i_pins.ce_n && !i_pins.oe_n && i_rst_n)
         o_dq = left > 0 && !susp ? {9'h0, tog, 6'h0} : rd(i_pins.addr);
      else
         o_dq = ~last;
endmodule : nfc_flash_model

// ===== verification/parallel_nor_flash_command_control_tb.sv
// Self-checking bench for the AHB-Lite flash controller.
`timescale 1ns/1ns
`include "nfc_map.svh"

module parallel_nor_flash_command_control_tb
   import nfc_pkg::*;
;
   logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hready, hresp, frst_n;
   logic [1:0] htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, v;
   logic [15:0] mdq, dq;
   logic done_pin, rst_seen = 0;
   nfc_pins_t pins;
   int fail_count = 0, tests_run = 0, cyc = 0;
   logic [15:0] exp_mem [int];

   always #2 clk = ~clk;
   assign dq = pins.dq_oe ? pins.dq_out : mdq;

   nfc_ctrl #(.BUSY_CYC(2), .RST_CYC(4), .RREC_CYC(2)) dut_u (
      .i_sys_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
      .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
      .o_hrdata(hrdata), .o_hresp(hresp), .i_dq_in(dq),
      .i_done_flag_pin(done_pin), .o_flash(pins), .o_flash_rst_n(frst_n));
   nfc_flash_model flash_u (.i_pins(pins), .i_rst_n(frst_n), .o_dq(mdq),
      .o_done_flag_pin(done_pin));

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (frst_n === 1'b0) rst_seen <= 1'b1;
      if (cyc == 40000)
      begin
         fail_count++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : finish_test

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (e !== g)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // ==========================================================
   // Bus tasks, entered just after a rising edge
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      v = hrdata;
      chk("hresp", 0, hresp);
   endtask : bus

   task automatic op(input logic [3:0] c, input logic [18:0] a, input logic [15:0] d);
      bus(`NFC_REG_ADDR, 1, {13'h0, a});
      bus(`NFC_REG_WDATA, 1, {16'h0, d});
      bus(`NFC_REG_CTRL, 1, {28'h0, c});
   endtask : op

   task automatic waitb(input int b, input logic lv);
      int n;
      n = 0;
      do
      begin
         bus(`NFC_REG_STATUS, 0, 0);
         n++;
      end
      while (v[b] !== lv && n < 5000);
      chk("wait", lv, v[b]);
   endtask : waitb

   function automatic logic [15:0] emem(input logic [18:0] a);
      return exp_mem.exists(a) ? exp_mem[a] : 16'hffff;
   endfunction : emem

   task automatic prog(input logic [18:0] a, input logic [15:0] d, input logic x8);
      op(4'h1, a, d);
      bus(`NFC_REG_STATUS, 0, 0);
      chk("busy", 1, v[0]);
      waitb(0, 1'b0);
      if (a[18:16] != 3'h6)
         exp_mem[a] = emem(a) & (x8 ? {8'hff, d[7:0]} : d);
   endtask : prog

   task automatic rdchk(input logic [18:0] a, input logic [15:0] m);
      op(4'h0, a, 16'h0);
      waitb(0, 1'b0);
      bus(`NFC_REG_RDATA, 0, 0);
      chk("array", {16'h0, emem(a) & m}, v & {16'hffff, m});
   endtask : rdchk

   task automatic erase(input int lo, input int n, input bit all);
      foreach (exp_mem[k])
         if ((all || (k >= lo && k < lo + n)) && k[18:16] != 3'h6)
            exp_mem[k] = 16'hffff;
   endtask : erase

   // ==========================================================
   // Tests
   initial
   begin
      logic [18:0] a;
      logic [18:0] q [$];
      void'($urandom(3257));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(`NFC_REG_CFG, 0, 0);
      chk("cfg", 32'h1, v);
      bus(`NFC_REG_STATUS, 0, 0);
      chk("status", 32'h20, v);
      bus(8'h40, 1, 32'h5);
      bus(8'h40, 0, 0);
      chk("unmapped", 0, v);
      chk("ce_n", 1, pins.ce_n);
      $display("test reset done");
      for (int i = 0; i < 3; i++)
      begin
         a = 19'($urandom) & 19'h07fff;
         q.push_back(a);
         prog(a, 16'($urandom), 0);
         rdchk(a, 16'hffff);
      end
      bus(`NFC_REG_CFG, 1, 0);
      a = 19'($urandom) & 19'h07fff;
      prog(a, 16'($urandom), 1);
      rdchk(a, 16'h00ff);
      bus(`NFC_REG_CFG, 1, 1);
      $display("test program done");
      op(4'h6, 0, 0);
      waitb(0, 1'b0);
      chk("bypass", 1, v[2]);
      op(4'h2, 0, 0);
      bus(`NFC_REG_STATUS, 0, 0);
      chk("refused", 1, v[3]);
      bus(`NFC_REG_STATUS, 1, 32'h8);
      bus(`NFC_REG_STATUS, 0, 0);
      chk("cleared", 0, v[3]);
      for (int i = 0; i < 2; i++)
      begin
         a = {4'h1, 15'($urandom)};
         q.push_back(a);
         prog(a, 16'($urandom), 0);
         rdchk(a, 16'hffff);
      end
      op(4'h7, 0, 0);
      waitb(0, 1'b0);
      chk("bypass off", 0, v[2]);
      a = {4'hd, 15'($urandom)};
      prog(a, 16'h0, 0);
      rdchk(a, 16'hffff);
      $display("test bypass done");
      op(4'h3, {4'h1, 15'h0}, 0);
      erase(32'h8000, 32'h8000, 0);
      waitb(5, 1'b0);
      waitb(4, 1'b1);
      op(4'h4, 0, 0);
      waitb(0, 1'b0);
      chk("suspended", 1, v[1]);
      rdchk(q[0], 16'hffff);
      op(4'h5, 0, 0);
      waitb(0, 1'b0);
      chk("resumed", 32'h20, v);
      foreach (q[i]) rdchk(q[i], 16'hffff);
      q.push_back(19'h05ffe);
      q.push_back(19'h06000);
      prog(q[5], 16'($urandom), 0);
      prog(q[6], 16'($urandom), 0);
      op(4'h3, 19'h04000, 0);
      erase(32'h4000, 32'h2000, 0);
      waitb(0, 1'b0);
      foreach (q[i]) rdchk(q[i], 16'hffff);
      $display("test erase done");
      op(4'h2, 0, 0);
      erase(0, 0, 1);
      waitb(5, 1'b0);
      op(4'h9, 0, 0);
      waitb(0, 1'b0);
      chk("restart pin", 1, rst_seen);
      chk("after restart", 32'h20, v);
      foreach (q[i]) rdchk(q[i], 16'hffff);
      $display("test restart done");
      finish_test();
   end
endmodule : parallel_nor_flash_command_control_tb
